// [hw/dwp_i2c_slave.sv]
// two-wire serial slave steering two wiper latches, two logic outputs and shutdown
`timescale 1ns/10ps
module dwp_i2c_slave
    import dwp_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       clk_en,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic       addr_select_pin_lo,
    input  wire logic       addr_select_pin_hi,
    input  wire logic       shutdown_pin_n,
    output logic [7:0]      wiper_pos_a,
    output logic [7:0]      wiper_pos_b,
    output logic            shutdown_a,
    output logic            shutdown_b,
    output logic            logic_out_a,
    output logic            logic_out_b,
    output logic            addressed
);
    import dwp_pkg::*;

    logic       rst_ff1_q;
    logic       rst_sync_n;
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic       scl_d_q;
    logic       sda_d_q;
    dwp_state_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic       oe_q;
    logic       rw_q;
    logic       mack_q;
    logic       ch_sel_q;
    logic       out_a_q;
    logic       out_b_q;
    logic [1:0] soft_sd_q;
    logic       sd_a_q;
    logic       sd_b_q;
    logic       wr_en_q;
    logic       mid_en_q;
    logic [7:0] wr_data_q;

    dwp_wiper_if wif ();

    // reset released through two flip-flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_ff1_q  <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_ff1_q  <= 1'b1;
            rst_sync_n <= rst_ff1_q;
        end
    end

    // two-stage synchronisers for every pin input
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sync1_q <= 5'h1F;
            sync2_q <= 5'h1F;
        end else if (clk_en) begin
            sync1_q <= {shutdown_pin_n, addr_select_pin_hi, addr_select_pin_lo, sda_i, scl_i};
            sync2_q <= sync1_q;
        end
    end

    wire scl_s  = sync2_q[0];
    wire sda_s  = sync2_q[1];
    wire sel_lo = sync2_q[2];
    wire sel_hi = sync2_q[3];
    wire shutdown_pin_n_n = sync2_q[4];

    // previous synchronised levels for edge finding
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else if (clk_en) begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
        end
    end

    // bus events
    wire scl_rise  = clk_en && scl_s && !scl_d_q;
    wire scl_fall  = clk_en && !scl_s && scl_d_q;
    wire start_det = clk_en && scl_s && scl_d_q && sda_d_q && !sda_s;
    wire stop_det  = clk_en && scl_s && scl_d_q && !sda_d_q && sda_s;
    wire byte_done = (cnt_q == BITS_PER_BYTE);
    wire hit       = addr_hit(rx_q, sel_hi, sel_lo);

    // serial engine: sample on clock rise, drive and advance on clock fall
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_q   <= ST_IDLE;
            cnt_q  <= 4'h0;
            rx_q   <= 8'h00;
            tx_q   <= 8'h00;
            oe_q   <= 1'b0;
            rw_q   <= 1'b0;
            mack_q <= 1'b0;
        end else if (start_det) begin
            st_q  <= ST_ADDR;
            cnt_q <= 4'h0;
            oe_q  <= 1'b0;
        end else if (stop_det) begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
        end else if (scl_rise) begin
            rx_q   <= {rx_q[6:0], sda_s};
            cnt_q  <= cnt_q + 4'h1;
            mack_q <= !sda_s;
        end else if (scl_fall) begin
            unique case (st_q)
                ST_IDLE: begin
                    oe_q <= 1'b0;
                end
                ST_ADDR: begin
                    if (byte_done && hit) begin
                        st_q <= ST_ADDR_ACK;
                        oe_q <= 1'b1;
                        rw_q <= rx_q[ADDR_RW_BIT];
                    end else if (byte_done) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    cnt_q <= 4'h0;
                    if (rw_q) begin
                        st_q <= ST_RDATA;
                        tx_q <= {wif.rd_data[6:0], 1'b0};
                        oe_q <= !wif.rd_data[7];
                    end else begin
                        st_q <= ST_INSTR;
                        oe_q <= 1'b0;
                    end
                end
                ST_INSTR: begin
                    if (byte_done) begin
                        st_q <= ST_INSTR_ACK;
                        oe_q <= 1'b1;
                    end
                end
                ST_INSTR_ACK, ST_WDATA_ACK: begin
                    st_q  <= ST_WDATA;
                    cnt_q <= 4'h0;
                    oe_q  <= 1'b0;
                end
                ST_WDATA: begin
                    if (byte_done) begin
                        st_q <= ST_WDATA_ACK;
                        oe_q <= 1'b1;
                    end
                end
                ST_RDATA: begin
                    if (byte_done) begin
                        st_q <= ST_RACK;
                        oe_q <= 1'b0;
                    end else begin
                        oe_q <= !tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                    end
                end
                ST_RACK: begin
                    cnt_q <= 4'h0;
                    if (mack_q) begin
                        st_q <= ST_RDATA;
                        tx_q <= {wif.rd_data[6:0], 1'b0};
                        oe_q <= !wif.rd_data[7];
                    end else begin
                        st_q <= ST_IDLE;
                        oe_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // instruction and data effects, taken when a byte completes
    wire instr_take = scl_fall && (st_q == ST_INSTR) && byte_done;
    wire data_take  = scl_fall && (st_q == ST_WDATA) && byte_done;

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ch_sel_q  <= 1'b0;
            out_a_q   <= LOGIC_OUT_RESET;
            out_b_q   <= LOGIC_OUT_RESET;
            soft_sd_q <= 2'b00;
            wr_en_q   <= 1'b0;
            mid_en_q  <= 1'b0;
            wr_data_q <= 8'h00;
        end else if (clk_en) begin
            wr_en_q  <= data_take;
            mid_en_q <= instr_take && rx_q[INSTR_MID_BIT];
            if (data_take) begin
                wr_data_q <= rx_q;
            end
            if (instr_take) begin
                ch_sel_q  <= rx_q[INSTR_CH_BIT];
                out_b_q   <= rx_q[INSTR_OUTB_BIT];
                out_a_q   <= rx_q[INSTR_OUTA_BIT];
                // any new instruction ends earlier soft shutdown
                soft_sd_q <= rx_q[INSTR_SD_BIT] ? {rx_q[INSTR_CH_BIT], !rx_q[INSTR_CH_BIT]} : 2'b00;
            end
        end
    end

    // effective shutdown per channel, latch content untouched
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sd_a_q <= 1'b0;
            sd_b_q <= 1'b0;
        end else if (clk_en) begin
            sd_a_q <= soft_sd_q[0] || !shutdown_pin_n_n;
            sd_b_q <= soft_sd_q[1] || !shutdown_pin_n_n;
        end
    end

    // bank request wiring
    assign wif.wr_en   = wr_en_q;
    assign wif.mid_en  = mid_en_q;
    assign wif.sel     = ch_sel_q;
    assign wif.wr_data = wr_data_q;

    dwp_wiper_bank u_bank (
        .mclk   (mclk),
        .rst_n  (rst_sync_n),
        .clk_en (clk_en),
        .wb     (wif.bank)
    );

    // pin and status outputs
    assign sda_o       = 1'b0;                                          // open drain: only pulls low
    assign sda_oe      = oe_q;
    assign wiper_pos_a = wif.pos_a;
    assign wiper_pos_b = wif.pos_b;
    assign shutdown_a  = sd_a_q;
    assign shutdown_b  = sd_b_q;
    assign logic_out_a = out_a_q;
    assign logic_out_b = out_b_q;
    assign addressed   = (st_q != ST_IDLE) && (st_q != ST_ADDR);

    chk_addr_miss: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (scl_fall && st_q == ST_ADDR && byte_done && !hit && !start_det && !stop_det) |=> st_q == ST_IDLE)
        else $error("unmatched address did not return to idle");

    chk_addr_ack: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (scl_fall && st_q == ST_ADDR && byte_done && hit && !start_det && !stop_det)
        |=> (st_q == ST_ADDR_ACK && sda_oe))
        else $error("matched address not acknowledged");

    chk_read_dir: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (scl_fall && st_q == ST_ADDR_ACK && rw_q && !start_det && !stop_det)
        |=> (st_q == ST_RDATA && sda_oe == !$past(wif.rd_data[7])))
        else $error("read direction did not start msb of latch");

    chk_instr_ack: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (st_q == ST_INSTR_ACK) |-> sda_oe)
        else $error("instruction byte not acknowledged");

    chk_scl_hold: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (scl_s && scl_d_q && $past(scl_s)) |-> $stable(sda_oe))
        else $error("data pin drive changed while clock high");

    chk_logic_out: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        instr_take |=> (logic_out_a == $past(rx_q[3]) && logic_out_b == $past(rx_q[4])))
        else $error("logic outputs not loaded from instruction");

    chk_wiper_load: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (data_take && !ch_sel_q) ##1 clk_en |=> wiper_pos_a == $past(wr_data_q))
        else $error("data byte did not reach wiper a");

    chk_rack_release: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (st_q == ST_RACK) |-> !sda_oe)
        else $error("data pin held during master acknowledge");

    chk_stop_idle: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        stop_det |=> (st_q == ST_IDLE && !sda_oe))
        else $error("stop did not release the slave");

    chk_pin_shutdown_pin_n: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (clk_en && !shutdown_pin_n_n) |=> (shutdown_a && shutdown_b))
        else $error("shutdown pin did not shut both channels");

    chk_wiper_load_b: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (data_take && ch_sel_q) ##1 clk_en |=> wiper_pos_b == $past(wr_data_q))
        else $error("data byte did not reach wiper b");

    chk_mid_recentre: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (instr_take && rx_q[INSTR_MID_BIT]) ##1 clk_en |=> (ch_sel_q ? wiper_pos_b : wiper_pos_a) == WIPER_MIDSCALE)
        else $error("midscale bit did not recentre the selected wiper");

    chk_soft_sd: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (instr_take && rx_q[INSTR_SD_BIT]) ##1 clk_en |=> (ch_sel_q ? shutdown_b : shutdown_a))
        else $error("soft shutdown bit did not shut the selected channel");

    chk_sd_release: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (instr_take && !rx_q[INSTR_SD_BIT]) ##1 (clk_en && shutdown_pin_n_n) |=> (!shutdown_a && !shutdown_b))
        else $error("new instruction did not end soft shutdown");

    chk_start_addr: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        start_det |=> (st_q == ST_ADDR && cnt_q == 4'h0 && !sda_oe))
        else $error("start did not reopen address reception");

    chk_latch_hold: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (!wif.wr_en && !wif.mid_en) |=> ($stable(wiper_pos_a) && $stable(wiper_pos_b)))
        else $error("wiper latch changed without a write");

    chk_rdata_bits: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (scl_fall && st_q == ST_RDATA && !byte_done) |=> (sda_oe == !$past(tx_q[7])))
        else $error("read data bit not shifted out in order");
endmodule

// [hw/dwp_pkg.sv]
// shared constants and types for the dual wiper two-wire slave
package dwp_pkg;
    // fixed upper five bits of the 7-bit slave address
    localparam logic [4:0] ADDR_PREFIX      = 5'h0B;
    // address byte field positions
    localparam int         ADDR_RW_BIT      = 0;
    localparam int         ADDR_SEL_LO_BIT  = 1;
    localparam int         ADDR_SEL_HI_BIT  = 2;
    // instruction byte field positions
    localparam int         INSTR_CH_BIT     = 7;
    localparam int         INSTR_MID_BIT    = 6;
    localparam int         INSTR_SD_BIT     = 5;
    localparam int         INSTR_OUTB_BIT   = 4;
    localparam int         INSTR_OUTA_BIT   = 3;
    // bits per byte before the acknowledge slot
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
    // values after reset
    localparam logic [7:0] WIPER_MIDSCALE   = 8'h80;
    localparam logic       LOGIC_OUT_RESET  = 1'b0;

    // serial engine states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_INSTR,
        ST_INSTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK
    } dwp_state_t;

    // true when an address byte names this device
    function automatic logic addr_hit(input logic [7:0] b, input logic hi, input logic lo);
        addr_hit = (b[7:3] == ADDR_PREFIX) && (b[ADDR_SEL_HI_BIT] == hi) && (b[ADDR_SEL_LO_BIT] == lo);
    endfunction
endpackage

// [hw/dwp_wiper_if.sv]
// link between the serial engine and the wiper latch bank
`timescale 1ns/10ps
interface dwp_wiper_if;
    logic       wr_en;
    logic       mid_en;
    logic       sel;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] pos_a;
    logic [7:0] pos_b;

    modport ctl  (output wr_en, output mid_en, output sel, output wr_data,
                  input rd_data, input pos_a, input pos_b);
    modport bank (input wr_en, input mid_en, input sel, input wr_data,
                  output rd_data, output pos_a, output pos_b);
endinterface

// [hw/dwp_wiper_bank.sv]
// two 8-bit wiper position latches with midscale preset and registered readback
`timescale 1ns/10ps
module dwp_wiper_bank
    import dwp_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  rst_n,
    input  wire logic  clk_en,
    dwp_wiper_if.bank  wb
);
    logic [7:0] lat_q [2];
    logic [7:0] rd_q;

    // latches preset to midscale, written or recentred per channel
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lat_q[0] <= WIPER_MIDSCALE;
            lat_q[1] <= WIPER_MIDSCALE;
        end else if (clk_en) begin
            if (wb.mid_en) begin
                lat_q[wb.sel] <= WIPER_MIDSCALE;
            end else if (wb.wr_en) begin
                lat_q[wb.sel] <= wb.wr_data;
            end
        end
    end

    // readback follows the selected channel one cycle late
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= WIPER_MIDSCALE;
        end else if (clk_en) begin
            rd_q <= lat_q[wb.sel];
        end
    end

    assign wb.rd_data = rd_q;
    assign wb.pos_a   = lat_q[0];
    assign wb.pos_b   = lat_q[1];
endmodule

// [verif/dwp_bus_master.sv]
// behavioural two-wire bus master that drives the slave from the far side
`timescale 1ns/10ps
module dwp_bus_master (
    input  wire logic mclk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_pull
);
    // link clock stands high and data is released between frames
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // a quarter of the 48 ns link period
    task automatic q();
        repeat (3) @(posedge mclk);
    endtask

    // start or repeated start: data falls while the clock is high
    task automatic start();
        q();
        sda_pull <= 1'b0;
        q();
        scl      <= 1'b1;
        q();
        sda_pull <= 1'b1;
        q();
        scl      <= 1'b0;
    endtask

    // stop: data rises while the clock is high
    task automatic stop();
        q();
        sda_pull <= 1'b1;
        q();
        scl      <= 1'b1;
        q();
        sda_pull <= 1'b0;
        q();
    endtask

    // one bit; data moves only in mid low phase, line read at end of high phase
    task automatic xbit(input logic rel, output logic r);
        q();
        sda_pull <= ~rel;
        q();
        scl      <= 1'b1;
        q();
        q();
        r   = sda_line;
        scl <= 1'b0;
    endtask

    // byte msb first, then the acknowledge slot; mack pulls the line in that slot
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            xbit(tx[i], rx[i]);
        end
        xbit(~mack, a);
        ack = ~a;
    endtask
endmodule

// [verif/tb.sv]
// self-checking bench for the dual wiper two-wire slave
`timescale 1ns/10ps
module tb;
    import dwp_pkg::*;
    logic       mclk;
    logic       rstn;
    logic       addr_select_pin_lo;
    logic       addr_select_pin_hi;
    logic       shutdown_pin_n;
    logic       scl;
    logic       m_pull;
    logic       sda_line;
    logic       sda_o;
    logic       sda_oe;
    logic [7:0] pos_a;
    logic [7:0] pos_b;
    logic       sd_a;
    logic       sd_b;
    logic       out_a;
    logic       out_b;
    logic       addressed;
    integer     n_errors = 0;
    integer     checked  = 0;
    integer     seed     = 22;
    int         exp_pos [2];
    int         exp_out [2];
    int         exp_sd  [2];
    int         sel;

    // 250 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // open-drain data line with pull-up
    assign sda_line = m_pull ? 1'b0 : (sda_oe ? sda_o : 1'b1);

    dwp_bus_master m (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_pull(m_pull));

    dwp_i2c_slave dut (
        .mclk(mclk), .rstn(rstn), .clk_en(1'b1), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_select_pin_lo(addr_select_pin_lo), .addr_select_pin_hi(addr_select_pin_hi),
        .shutdown_pin_n(shutdown_pin_n), .wiper_pos_a(pos_a), .wiper_pos_b(pos_b), .shutdown_a(sd_a),
        .shutdown_b(sd_b), .logic_out_a(out_a), .logic_out_b(out_b), .addressed(addressed)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (n_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // model back to its power-up state
    task automatic model_reset();
        exp_pos = '{128, 128};
        exp_out = '{0, 0};
        exp_sd  = '{0, 0};
        sel     = 0;
    endtask

    // compare every latched output with the model
    task automatic check_state();
        // let a stop seen at the last edge settle through the engine
        repeat (4) @(posedge mclk);
        check(pos_a, 8'(exp_pos[0]));
        check(pos_b, 8'(exp_pos[1]));
        check({7'h00, out_a}, 8'(exp_out[0]));
        check({7'h00, out_b}, 8'(exp_out[1]));
        check({7'h00, sd_a}, 8'(exp_sd[0] | int'(!shutdown_pin_n)));
        check({7'h00, sd_b}, 8'(exp_sd[1] | int'(!shutdown_pin_n)));
        check({7'h00, addressed}, 8'h00);
    endtask

    function automatic logic [7:0] addr_byte(input logic rw);
        return {ADDR_PREFIX, addr_select_pin_hi, addr_select_pin_lo, rw};
    endfunction

    // hang guard
    initial begin
        repeat (60000) @(posedge mclk);
        n_errors++;
        summarize();
    end

    // main sequence
    initial begin
        logic [7:0] rx;
        logic [7:0] ins;
        logic [7:0] d;
        logic       ack;
        int         nd;
        rstn               = 1'b0;
        addr_select_pin_lo = 1'($random(seed));
        addr_select_pin_hi = 1'($random(seed));
        shutdown_pin_n     = 1'b1;
        model_reset();
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        repeat (10) @(posedge mclk);
        check_state();
        // each select bit flipped, then a wrong prefix: no acknowledge
        for (int k = 0; k < 3; k++) begin
            d = addr_byte(1'b0) ^ ((k == 0) ? 8'h02 : (k == 1) ? 8'h04 : 8'h80);
            m.start();
            m.xfer(d, 1'b0, rx, ack);
            check({7'h00, ack}, 8'h00);
            check({7'h00, addressed}, 8'h00);
            m.stop();
        end
        // random instruction, data and readback frames
        for (int i = 0; i < 10; i++) begin
            shutdown_pin_n <= ($random(seed) % 4) != 0;
            ins = 8'($random(seed));
            nd  = ($random(seed) & 32'h3) % 3;
            if (nd == 0) begin
                ins[INSTR_MID_BIT] = 1'b0;
            end
            m.start();
            m.xfer(addr_byte(1'b0), 1'b0, rx, ack);
            check({7'h00, ack}, 8'h01);
            m.xfer(ins, 1'b0, rx, ack);
            check({7'h00, ack}, 8'h01);
            sel         = int'(ins[INSTR_CH_BIT]);
            exp_sd      = '{0, 0};
            exp_sd[sel] = int'(ins[INSTR_SD_BIT]);
            exp_out[0]  = int'(ins[INSTR_OUTA_BIT]);
            exp_out[1]  = int'(ins[INSTR_OUTB_BIT]);
            if (ins[INSTR_MID_BIT]) begin
                exp_pos[sel] = 128;
            end
            for (int j = 0; j < nd; j++) begin
                d = 8'($random(seed));
                m.xfer(d, 1'b0, rx, ack);
                check({7'h00, ack}, 8'h01);
                exp_pos[sel] = int'(d);
            end
            if ($random(seed) & 1) begin
                m.stop();
                check_state();
                m.start();
            end else begin
                m.start();
            end
            m.xfer(addr_byte(1'b1), 1'b0, rx, ack);
            check({7'h00, ack}, 8'h01);
            check({7'h00, addressed}, 8'h01);
            m.xfer(8'hFF, 1'b1, rx, ack);
            check(rx, 8'(exp_pos[sel]));
            m.xfer(8'hFF, 1'b0, rx, ack);
            check(rx, 8'(exp_pos[sel]));
            m.stop();
            check_state();
        end
        // second reset in mid-run restores power-up values
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        model_reset();
        repeat (10) @(posedge mclk);
        check_state();
        summarize();
    end
endmodule
